//--- hdl/prox_host_if.sv
`default_nettype none
module prox_host_if #(
  parameter int OSC_CYCLES = prox_pkg::OSC_CYCLES
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic scl_oe_o,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic addr_lsb_pin_i,
  input wire logic sample_clk_i,
  output logic sample_clk_o,
  input wire logic irq_cascade_input_n_i,
  output logic irq_out_low_n_o,
  input wire logic [7:0] sensor_i,
  input wire logic [7:0] charge_near_i,
  input wire logic [7:0] charge_done_i,
  output logic [7:0] fast_charge_o,
  output logic [7:0] fine_charge_o,
  output logic [7:0] counter_en_o,
  output logic [2:0] sample_chan_o,
  output logic sample_strobe_o,
  output logic regulator_off_o,
  output logic sleep_o,
  output logic [7:0] config_o,
  output logic [7:0] timing_o,
  output logic [7:0] mask_o
);
  ////////////////////////////////////////////////////////////////
  // Pin synchronisers: first stage only feeds second
  logic [4:0] sy1, sy2, sy3;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sy1 <= 5'h1f;
      sy2 <= 5'h1f;
      sy3 <= 5'h1f;
    end else begin
      sy1 <= {irq_cascade_input_n_i, sample_clk_i, addr_lsb_pin_i, sda_i, scl_i};
      sy2 <= sy1;
      sy3 <= sy2;
    end
  end
  wire logic scl = sy2[0];
  wire logic sda = sy2[1];
  wire logic scl_rise = sy2[0] && !sy3[0];
  wire logic scl_fall = !sy2[0] && sy3[0];
  wire logic start_seen = scl && sy3[0] && !sda && sy3[1];
  wire logic stop_seen = scl && sy3[0] && sda && !sy3[1];

  ////////////////////////////////////////////////////////////////
  // Registers and slave state
  typedef enum {S_IDLE, S_ADDR, S_ADDR_ACK, S_CMD, S_CMD_ACK, S_DATA, S_DATA_ACK,
                S_TX, S_TX_ACK, S_SKIP} slv_t;
  typedef enum {M_IDLE, M_START, M_HOLD, M_STOP} mst_t;
  slv_t st, next_st;
  mst_t mst, next_mst;
  prox_pkg::regs_t regs, next_regs;
  logic [7:0] sh, next_sh, cmd, next_cmd, touch_state_reg, next_touch_state_reg;
  logic [3:0] bits, next_bits;
  logic rw, next_rw, irq, next_irq, sleep, next_sleep, sda_low, next_sda_low;
  logic direct, next_direct, soft_rst;
  logic [5:0] mcnt, next_mcnt;
  logic [7:0] touch_state_reg_new;
  logic own_event;
  wire logic [1:0] role = regs.config_reg[prox_pkg::ROLE_MSB:prox_pkg::ROLE_LSB];
  wire logic is_sec = (role == prox_pkg::ROLE_SECONDARY);
  wire logic is_pri = (role == prox_pkg::ROLE_PRIMARY);

  always_comb begin
    next_st = st;
    next_regs = regs;
    next_sh = sh;
    next_cmd = cmd;
    next_bits = bits;
    next_rw = rw;
    next_sleep = sleep;
    next_sda_low = sda_low;
    next_direct = direct;
    soft_rst = 1'b0;
    next_touch_state_reg = touch_state_reg_new;
    next_irq = irq;
    if (start_seen) begin
      next_st = S_ADDR;
      next_bits = 4'h0;
      next_sda_low = 1'b0;
    end else if (stop_seen) begin
      next_st = S_IDLE;
      next_sda_low = 1'b0;
      // Stale read command must not turn a later direct read into a register read
      next_cmd = 8'hff;
    end else begin
      unique case (st)
        S_IDLE, S_SKIP: next_sda_low = 1'b0;
        S_ADDR, S_CMD, S_DATA: begin
          if (scl_rise) begin
            next_sh = {sh[6:0], sda};
            next_bits = bits + 4'h1;
          end
          if (scl_fall && bits == 4'h8) begin
            next_bits = 4'h0;
            if (st == S_ADDR) begin
              if (sh[7:1] == {prox_pkg::BASE_ADDR, sy2[2]}) begin
                next_sda_low = 1'b1;
                next_rw = sh[0];
                next_st = S_ADDR_ACK;
              end else begin
                next_st = S_SKIP;
              end
            end else begin
              next_sda_low = 1'b1;
              next_st = (st == S_CMD) ? S_CMD_ACK : S_DATA_ACK;
            end
          end
        end
        S_ADDR_ACK: if (scl_fall) begin
          next_sda_low = 1'b0;
          if (rw) begin
            // Read after a read command returns its register, else sensor state
            next_direct = !(cmd inside {prox_pkg::OP_CFG_RD, prox_pkg::OP_TIM_RD,
                                         prox_pkg::OP_MSK_RD});
            unique case (cmd)
              prox_pkg::OP_CFG_RD: next_sh = regs.config_reg;
              prox_pkg::OP_TIM_RD: next_sh = regs.timing_setting_reg;
              prox_pkg::OP_MSK_RD: next_sh = regs.mask;
              default: next_sh = touch_state_reg;
            endcase
            next_sda_low = !next_sh[7];
            next_st = S_TX;
          end else begin
            next_cmd = 8'hff;
            next_st = S_CMD;
          end
        end
        S_CMD_ACK: if (scl_fall) begin
          next_sda_low = 1'b0;
          next_cmd = sh;
          next_st = S_DATA;
          unique case (sh)
            prox_pkg::OP_SOFT_RESET: soft_rst = 1'b1;
            prox_pkg::OP_IRQ_CLEAR: next_irq = 1'b0;
            prox_pkg::OP_SLEEP: next_sleep = 1'b1;
            prox_pkg::OP_WAKE: next_sleep = 1'b0;
            prox_pkg::OP_BUS_IRQ: next_regs.bus_irq_on = 1'b1;
            default: ;
          endcase
        end
        S_DATA_ACK: if (scl_fall) begin
          next_sda_low = 1'b0;
          next_st = S_SKIP;
          unique case (cmd)
            prox_pkg::OP_CFG_WR: next_regs.config_reg = sh;
            prox_pkg::OP_TIM_WR: next_regs.timing_setting_reg = sh;
            prox_pkg::OP_MSK_WR: next_regs.mask = sh;
            default: ;
          endcase
        end
        S_TX: begin
          if (scl_fall) begin
            next_bits = bits + 4'h1;
            next_sh = {sh[6:0], 1'b0};
            next_sda_low = (bits == 4'h7) ? 1'b0 : !sh[6];
            if (bits == 4'h7) next_st = S_TX_ACK;
          end
        end
        S_TX_ACK: begin
          // NACK ends the read; after an ACK a direct read reloads on the fall, a register read ends
          if (scl_rise && sda) next_st = S_SKIP;
          if (scl_fall) begin
            next_bits = 4'h0;
            next_sda_low = 1'b0;
            next_st = S_SKIP;
            if (direct) begin
              next_sh = touch_state_reg;
              next_sda_low = !touch_state_reg[7];
              next_st = S_TX;
            end
          end
        end
        default: next_st = S_IDLE;
      endcase
    end
    // Direct read clears the interrupt when the address ACK ends, before the byte goes out
    if (st == S_ADDR_ACK && scl_fall && rw && next_direct) next_irq = 1'b0;
    if (own_event) next_irq = 1'b1; // Set wins over clear, but soft reset wins over set
    if (soft_rst) begin
      next_regs = '{prox_pkg::CONFIG_RST, prox_pkg::TIMING_RST, prox_pkg::MASK_RST, 1'b0};
      next_sleep = 1'b0;
      next_irq = 1'b0;
      next_touch_state_reg = 8'h00;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st <= S_IDLE;
      regs <= '{prox_pkg::CONFIG_RST, prox_pkg::TIMING_RST, prox_pkg::MASK_RST, 1'b0};
      sh <= 8'h00;
      cmd <= 8'hff;
      bits <= 4'h0;
      rw <= 1'b0;
      irq <= 1'b0;
      sleep <= 1'b0;
      sda_low <= 1'b0;
      direct <= 1'b0;
      touch_state_reg <= 8'h00;
    end else begin
      st <= next_st;
      regs <= next_regs;
      sh <= next_sh;
      cmd <= next_cmd;
      bits <= next_bits;
      rw <= next_rw;
      irq <= next_irq;
      sleep <= next_sleep;
      sda_low <= next_sda_low;
      direct <= next_direct;
      touch_state_reg <= next_touch_state_reg;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Sample timing: oscillator tick, divider, channel scan
  logic [7:0] osc_cnt, next_osc_cnt;
  logic [5:0] div_cnt, next_div_cnt;
  logic [2:0] chan, next_chan;
  logic samp_clk, next_samp_clk, tick;
  logic [5:0] div_max;
  always_comb begin
    unique case (regs.timing_setting_reg[prox_pkg::DIV_LSB +: 2])
      2'h0: div_max = 6'd0;
      2'h1: div_max = 6'd3;
      2'h2: div_max = 6'd15;
      default: div_max = 6'd63;
    endcase
    next_osc_cnt = osc_cnt;
    next_div_cnt = div_cnt;
    next_samp_clk = samp_clk;
    tick = 1'b0;
    if (is_sec) begin
      next_osc_cnt = 8'h00;
      next_div_cnt = 6'h00;
      tick = !sy2[3] && sy3[3];
    end else if (!sleep) begin
      next_osc_cnt = (osc_cnt == 8'(OSC_CYCLES - 1)) ? 8'h00 : osc_cnt + 8'h01;
      if (osc_cnt == 8'(OSC_CYCLES - 1)) begin
        next_div_cnt = (div_cnt >= div_max) ? 6'h00 : div_cnt + 6'h01;
        if (div_cnt >= div_max) begin
          next_samp_clk = !samp_clk;
          tick = !samp_clk;
        end
      end
    end
    next_chan = tick ? chan + 3'h1 : chan;
  end
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      osc_cnt <= 8'h00;
      div_cnt <= 6'h00;
      chan <= 3'h0;
      samp_clk <= 1'b0;
    end else begin
      osc_cnt <= next_osc_cnt;
      div_cnt <= next_div_cnt;
      chan <= next_chan;
      samp_clk <= next_samp_clk;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Per-channel start-up and sensor state
  logic [7:0] run, next_run, near, next_near;
  always_comb begin
    next_run = run;
    next_near = near;
    touch_state_reg_new = touch_state_reg;
    own_event = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (!regs.mask[i] || sleep) begin
        next_run[i] = 1'b0;
        next_near[i] = 1'b0;
      end else if (!near[i]) next_near[i] = charge_near_i[i];
      else if (!run[i]) next_run[i] = charge_done_i[i];
      if (tick && chan == 3'(i) && run[i]) touch_state_reg_new[i] = sensor_i[i];
    end
    own_event = (touch_state_reg_new != touch_state_reg);
  end
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      run <= 8'h00;
      near <= 8'h00;
    end else begin
      run <= next_run;
      near <= next_near;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Interrupt over the bus: START then STOP only, bus must be idle
  logic irq_q, next_irq_q;
  always_comb begin
    next_mst = mst;
    next_mcnt = mcnt;
    next_irq_q = irq;
    if (mst != M_IDLE) next_mcnt = mcnt + 6'h01;
    unique case (mst)
      M_IDLE: if (irq && !irq_q && regs.bus_irq_on && st == S_IDLE && scl && sda) begin
        next_mst = M_START;
        next_mcnt = 6'h00;
      end
      M_START: if (mcnt == 6'(prox_pkg::BUS_HALF_CYCLES)) next_mst = M_HOLD;
      M_HOLD: if (mcnt == 6'(2 * prox_pkg::BUS_HALF_CYCLES)) next_mst = M_STOP;
      M_STOP: if (mcnt == 6'(3 * prox_pkg::BUS_HALF_CYCLES)) next_mst = M_IDLE;
    endcase
  end
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mst <= M_IDLE;
      mcnt <= 6'h00;
      irq_q <= 1'b0;
    end else begin
      mst <= next_mst;
      mcnt <= next_mcnt;
      irq_q <= next_irq_q;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Outputs
  assign sda_o = 1'b0;
  assign sda_oe_o = sda_low || (mst != M_IDLE && mst != M_STOP) || mst == M_STOP && mcnt < 6'(3 * prox_pkg::BUS_HALF_CYCLES);
  assign scl_o = 1'b0;
  assign scl_oe_o = (mst == M_HOLD);
  assign irq_out_low_n_o = !(irq || (is_sec && !sy2[4]));
  assign sample_clk_o = is_pri ? samp_clk : 1'b0;
  assign sample_chan_o = chan;
  assign sample_strobe_o = tick;
  assign fast_charge_o = regs.mask & ~near;
  assign fine_charge_o = regs.mask & near & ~run;
  assign counter_en_o = run;
  assign regulator_off_o = regs.config_reg[prox_pkg::REGULATOR_OFF_BIT_BIT];
  assign sleep_o = sleep;
  assign config_o = regs.config_reg;
  assign timing_o = regs.timing_setting_reg;
  assign mask_o = regs.mask;
endmodule : prox_host_if
`default_nettype wire

//--- include/prox_pkg.sv
`default_nettype none
package prox_pkg;
  localparam logic [5:0] BASE_ADDR = 6'h10;
  localparam logic [7:0] OP_SOFT_RESET = 8'h00;
  localparam logic [7:0] OP_IRQ_CLEAR = 8'h03;
  localparam logic [7:0] OP_SLEEP = 8'h05;
  localparam logic [7:0] OP_WAKE = 8'h06;
  localparam logic [7:0] OP_CFG_WR = 8'h30;
  localparam logic [7:0] OP_CFG_RD = 8'h33;
  localparam logic [7:0] OP_TIM_WR = 8'h35;
  localparam logic [7:0] OP_TIM_RD = 8'h36;
  localparam logic [7:0] OP_MSK_WR = 8'h39;
  localparam logic [7:0] OP_MSK_RD = 8'h3a;
  localparam logic [7:0] OP_BUS_IRQ = 8'h3c;
  localparam logic [7:0] CONFIG_RST = 8'h00;
  localparam logic [7:0] TIMING_RST = 8'h0c;
  localparam logic [7:0] MASK_RST = 8'hff;
  localparam int ROLE_MSB = 7;
  localparam int ROLE_LSB = 6;
  localparam int REGULATOR_OFF_BIT_BIT = 2;
  localparam logic [1:0] ROLE_ALONE = 2'h0;
  localparam logic [1:0] ROLE_SECONDARY = 2'h1;
  localparam logic [1:0] ROLE_PRIMARY = 2'h2;
  localparam int FINE_LSB = 0;
  localparam int COARSE_LSB = 3;
  localparam int DIV_LSB = 6;
  localparam int OSC_HZ = 128000;
  localparam int CLK_HZ = 20000000;
  localparam int OSC_CYCLES = CLK_HZ / OSC_HZ;
  localparam int FAST_STEPS = 16;
  localparam int FINE_STEPS = 8;
  localparam int BUS_HALF_NS = 500;
  localparam int CLK_NS = 50;
  localparam int BUS_HALF_CYCLES = (BUS_HALF_NS + CLK_NS - 1) / CLK_NS;
  typedef struct packed {
    logic [7:0] config_reg;
    logic [7:0] timing_setting_reg;
    logic [7:0] mask;
    logic bus_irq_on;
  } regs_t;
endpackage : prox_pkg
`default_nettype wire

//--- testbench/i2c_ctrl_model.sv
`default_nettype none
module i2c_ctrl_model (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_oe_o,
  output logic sda_oe_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scl_oe_o = 1'b0;
    sda_oe_o = 1'b0;
  end
  task automatic hp();
    repeat (10) @(negedge clk_i);
  endtask : hp
  // Also serves as repeated start from scl low
  task automatic start();
    sda_oe_o <= 1'b0;
    hp();
    scl_oe_o <= 1'b0;
    hp();
    sda_oe_o <= 1'b1;
    hp();
    scl_oe_o <= 1'b1;
  endtask : start
  // Data moves a few cycles after scl falls, never with it
  task automatic xfer(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      repeat (3) @(negedge clk_i);
      sda_oe_o <= !d[i];
      hp();
      scl_oe_o <= 1'b0;
      hp();
      q[i] = sda_i;
      scl_oe_o <= 1'b1;
    end
  endtask : xfer
  task automatic stop();
    repeat (3) @(negedge clk_i);
    sda_oe_o <= 1'b1;
    hp();
    scl_oe_o <= 1'b0;
    hp();
    sda_oe_o <= 1'b0;
    hp();
  endtask : stop
endmodule : i2c_ctrl_model
`default_nettype wire

//--- testbench/prox_props.sv
`default_nettype none
module prox_props (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe_o,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic sample_clk_i,
  input wire logic sample_clk_o,
  input wire logic irq_cascade_input_n_i,
  input wire logic irq_out_low_n_o,
  input wire logic [7:0] fast_charge_o,
  input wire logic [7:0] fine_charge_o,
  input wire logic [7:0] counter_en_o,
  input wire logic sample_strobe_o,
  input wire logic [7:0] config_o,
  input wire logic [7:0] timing_o,
  input wire logic [7:0] mask_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  logic [1:0] role;
  assign role = config_o[prox_pkg::ROLE_MSB:prox_pkg::ROLE_LSB];
  sequence s_scl_free;
    $fell(scl_oe_o);
  endsequence
  sequence s_sda_free;
    ##[0:40] !sda_oe_o;
  endsequence
  a_scl_low_only: assert property (scl_o == 1'b0)
    else $error("scl driven high");
  a_sda_low_only: assert property (sda_o == 1'b0)
    else $error("sda driven high");
  a_reset_defaults: assert property (!$past(nrst_i) |-> config_o == prox_pkg::CONFIG_RST
    && timing_o == prox_pkg::TIMING_RST && mask_o == prox_pkg::MASK_RST) else $error("bad reset values");
  a_scl_pulse_short: assert property ($rose(scl_oe_o) |-> ##[1:40] !scl_oe_o)
    else $error("scl held too long");
  a_stop_follows: assert property (s_scl_free |-> s_sda_free)
    else $error("no stop after start");
  a_cascade_or: assert property (role == prox_pkg::ROLE_SECONDARY && !irq_cascade_input_n_i
    |-> ##[0:4] !irq_out_low_n_o) else $error("cascade irq lost");
  a_clkout_idle: assert property ((role != prox_pkg::ROLE_PRIMARY)[*4] |-> $stable(sample_clk_o))
    else $error("clock out moves");
  a_secondary_quiet: assert property ((role == prox_pkg::ROLE_SECONDARY && $stable(sample_clk_i))[*8]
    |-> !sample_strobe_o) else $error("own clock in secondary");
  a_strobe_single: assert property (sample_strobe_o |=> !sample_strobe_o)
    else $error("strobe too long");
  a_phase_exclusive: assert property ((counter_en_o & (fast_charge_o | fine_charge_o)) == 8'h00)
    else $error("counter on while charging");
endmodule : prox_props
bind prox_host_if prox_props prox_props_inst (.clk_i, .nrst_i, .scl_i, .scl_o, .scl_oe_o, .sda_o, .sda_oe_o,
  .sample_clk_i, .sample_clk_o, .irq_cascade_input_n_i, .irq_out_low_n_o, .fast_charge_o, .fine_charge_o,
  .counter_en_o, .sample_strobe_o, .config_o, .timing_o, .mask_o);
`default_nettype wire

//--- testbench/proximity_switch_host_interface_test.sv
`default_nettype none
module proximity_switch_host_interface_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [6:0] ADR = {prox_pkg::BASE_ADDR, 1'b1};
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic scl_i, sda_i, scl_o, scl_oe_o, sda_o, sda_oe_o, m_scl, m_sda, sample_clk_o, irq_out_low_n_o;
  logic addr_lsb_pin_i, sample_clk_i, irq_cascade_input_n_i, sample_strobe_o, regulator_off_o, sleep_o;
  logic [7:0] sensor_i, charge_near_i, charge_done_i, fast_charge_o, fine_charge_o, counter_en_o;
  logic [7:0] config_o, timing_o, mask_o, d;
  logic [2:0] sample_chan_o;
  logic [7:0] ex [3];
  logic [7:0] wop [3] = '{prox_pkg::OP_CFG_WR, prox_pkg::OP_TIM_WR, prox_pkg::OP_MSK_WR};
  logic [7:0] rop [3] = '{prox_pkg::OP_CFG_RD, prox_pkg::OP_TIM_RD, prox_pkg::OP_MSK_RD};
  logic [31:0] seed = 32'h0000_5f0d;
  logic ok, sda_d, sclk_d;
  int errors = 0;
  int tests_run = 0;
  int starts, scl_hits, toggles, strobes;
  // Pull-ups: a released line reads high
  assign scl_i = !(scl_oe_o | m_scl);
  assign sda_i = !(sda_oe_o | m_sda);
  always #25 clk_i = ~clk_i;
  prox_host_if #(.OSC_CYCLES(8)) prox_host_if_inst (.clk_i, .nrst_i, .scl_i, .sda_i, .scl_o, .scl_oe_o,
    .sda_o, .sda_oe_o, .addr_lsb_pin_i, .sample_clk_i, .sample_clk_o, .irq_cascade_input_n_i,
    .irq_out_low_n_o, .sensor_i, .charge_near_i, .charge_done_i, .fast_charge_o, .fine_charge_o,
    .counter_en_o, .sample_chan_o, .sample_strobe_o, .regulator_off_o, .sleep_o, .config_o, .timing_o, .mask_o);
  i2c_ctrl_model ctrl (.clk_i, .sda_i, .scl_oe_o(m_scl), .sda_oe_o(m_sda));
  always @(posedge clk_i) begin
    if (sda_oe_o && !sda_d && scl_i) starts++;
    if (scl_oe_o) scl_hits++;
    if (sample_clk_o !== sclk_d) toggles++;
    if (sample_strobe_o) strobes++;
    sda_d <= sda_oe_o;
    sclk_d <= sample_clk_o;
  end
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic chk_regs();
    chk("config", ex[0], config_o);
    chk("timing", ex[1], timing_o);
    chk("mask", ex[2], mask_o);
  endtask : chk_regs
  task automatic rst_model();
    ex = '{prox_pkg::CONFIG_RST, prox_pkg::TIMING_RST, prox_pkg::MASK_RST};
  endtask : rst_model
  task automatic wr(input logic [6:0] a, input logic [7:0] c, input bit dat, input logic [7:0] v, output logic k);
    logic [8:0] q0, q1, q2;
    q2 = 9'h000;
    ctrl.start();
    ctrl.xfer({a, 2'b01}, q0);
    ctrl.xfer({c, 1'b1}, q1);
    if (dat) ctrl.xfer({v, 1'b1}, q2);
    ctrl.stop();
    k = !q0[0] && !q1[0] && !q2[0];
  endtask : wr
  task automatic rd(input bit cmd, input logic [7:0] c, input int n, input logic [7:0] e);
    logic [8:0] q;
    if (cmd) begin
      ctrl.start();
      ctrl.xfer({ADR, 2'b01}, q);
      ctrl.xfer({c, 1'b1}, q);
    end
    ctrl.start();
    ctrl.xfer({ADR, 2'b11}, q);
    for (int k = 1; k <= n; k++) begin
      ctrl.xfer({8'hff, k == n}, q);
      chk("read", e, q[8:1]);
    end
    ctrl.stop();
  endtask : rd
  task automatic wait_irq(input logic v);
    for (int k = 0; k < 5000 && irq_out_low_n_o !== v; k++) @(negedge clk_i);
  endtask : wait_irq
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (95000) @(posedge clk_i);
    errors++;
    close_out();
  end
  initial begin
    {addr_lsb_pin_i, irq_cascade_input_n_i, sample_clk_i} = 3'b110;
    {sensor_i, charge_near_i, charge_done_i} = 24'h00_0000;
    rst_model();
    repeat (5) @(negedge clk_i);
    nrst_i = 1'b1;
    repeat (3) @(negedge clk_i);
    chk_regs();
    chk("regulator_off_bit", 8'h00, {7'h00, regulator_off_o});
    chk("irq", 8'h01, {7'h00, irq_out_low_n_o});
    repeat (200) @(negedge clk_i);
    chk("fast", 8'hff, fast_charge_o);
    charge_near_i = 8'hff;
    repeat (200) @(negedge clk_i);
    chk("fine", 8'hff, fine_charge_o);
    charge_done_i = 8'hff;
    repeat (200) @(negedge clk_i);
    chk("count", 8'hff, counter_en_o);
    $display("test startup done");
    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      d = (i == 0) ? ((seed[7:0] & 8'h27) | 8'h04) : seed[7:0];
      wr(ADR, wop[i], 1'b1, d, ok);
      ex[i] = d;
      chk("ack", 8'h01, {7'h00, ok});
      chk_regs();
      rd(1'b1, rop[i], 1, d);
    end
    chk("regulator_off_bit", 8'h01, {7'h00, regulator_off_o});
    wr({prox_pkg::BASE_ADDR, 1'b0}, prox_pkg::OP_MSK_WR, 1'b1, 8'h5a, ok);
    chk("nack", 8'h00, {7'h00, ok});
    wr(ADR, 8'h77, 1'b0, 8'h00, ok);
    chk("ack", 8'h01, {7'h00, ok});
    chk_regs();
    wr(ADR, prox_pkg::OP_SLEEP, 1'b0, 8'h00, ok);
    chk("sleep", 8'h01, {7'h00, sleep_o});
    wr(ADR, prox_pkg::OP_WAKE, 1'b0, 8'h00, ok);
    chk("sleep", 8'h00, {7'h00, sleep_o});
    wr(ADR, prox_pkg::OP_SOFT_RESET, 1'b0, 8'h00, ok);
    rst_model();
    chk_regs();
    chk("regulator_off_bit", 8'h00, {7'h00, regulator_off_o});
    $display("test registers done");
    sensor_i = 8'ha5;
    wait_irq(1'b0);
    chk("irq", 8'h00, {7'h00, irq_out_low_n_o});
    rd(1'b0, 8'h00, 2, 8'ha5);
    chk("irq", 8'h01, {7'h00, irq_out_low_n_o});
    sensor_i = 8'h00;
    wait_irq(1'b0);
    wr(ADR, prox_pkg::OP_IRQ_CLEAR, 1'b0, 8'h00, ok);
    chk("irq", 8'h01, {7'h00, irq_out_low_n_o});
    scl_hits = 0;
    sensor_i = 8'h3c;
    wait_irq(1'b0);
    repeat (100) @(negedge clk_i);
    chk("scl", 8'h00, 8'(scl_hits));
    rd(1'b0, 8'h00, 1, 8'h3c);
    wr(ADR, prox_pkg::OP_BUS_IRQ, 1'b0, 8'h00, ok);
    starts = 0;
    sensor_i = 8'h00;
    wait_irq(1'b0);
    repeat (100) @(negedge clk_i);
    chk("start", 8'h01, 8'(starts));
    chk("irq", 8'h00, {7'h00, irq_out_low_n_o});
    rd(1'b0, 8'h00, 1, 8'h00);
    $display("test interrupts done");
    wr(ADR, prox_pkg::OP_CFG_WR, 1'b1, {prox_pkg::ROLE_PRIMARY, 6'h00}, ok);
    toggles = 0;
    repeat (400) @(negedge clk_i);
    chk("clkout", 8'h01, {7'h00, toggles > 0});
    wr(ADR, prox_pkg::OP_CFG_WR, 1'b1, {prox_pkg::ROLE_SECONDARY, 6'h00}, ok);
    irq_cascade_input_n_i = 1'b0;
    repeat (10) @(negedge clk_i);
    chk("cascade", 8'h00, {7'h00, irq_out_low_n_o});
    irq_cascade_input_n_i = 1'b1;
    strobes = 0;
    repeat (40) begin
      repeat (20) @(negedge clk_i);
      sample_clk_i = ~sample_clk_i;
    end
    chk("strobe", 8'h01, {7'h00, strobes > 0});
    $display("test roles done");
    close_out();
  end
endmodule : proximity_switch_host_interface_test
`default_nettype wire
